/* File: hdl/timer16_counter_input_capture.sv */
/*
  16-bit up/down counter with shared high-byte latch and input capture.
  assumes cpu byte accesses arrive as one-cycle strobes on i_ref_clk, and
  that prescaler strobes and pins are already synchronous to that clock.
*/
`default_nettype none
// Function
// - three-bit select picks tick, zero stops
// - high locations use latch, except compare a high reads, low byte commits
// - each tick clears, increments or decrements counter
// - cpu write beats clear or count
// - counter accessible with tick stopped
// - overflow flag set per mode, raises interrupt
// - bottom at zero, top at sequence top
// - qualifying edge copies counter, sets capture flag
// - flag requests interrupt, clears when serviced
// - writing one clears capture flag
// - capture low read loads latch for high
// - capture writable only in capture-top modes
// - trigger is pin, or comparator when selected
// - filter changes after four agreeing samples
// - filter adds exactly four cycles delay
// - filter runs on undivided system clock
// - capture inputs off in capture-top modes
// - software pin drive also triggers capture
// - new capture always overwrites capture register
// - top is fixed, compare a, or capture
module timer16_counter_input_capture (
  // clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_reset,
  // cpu byte access
  input  wire timer16_pkg::cpu_req_t   i_cpu_req,
  output logic [7:0]                   o_cpu_rdata,
  // control bits
  input  wire timer16_pkg::timer_ctrl_t i_ctrl,
  input  wire logic                    i_capture_flag_clear,
  input  wire logic                    i_capture_irq_ack,
  input  wire logic                    i_overflow_flag_clear,
  input  wire logic                    i_overflow_irq_ack,
  // tick sources
  input  wire logic [3:0]              i_prescale_tick,
  input  wire logic                    i_ext_tick_pin,
  // capture sources
  input  wire logic                    i_capture_pin,
  input  wire logic                    i_comparator_output,
  // status and waveform links
  output logic [15:0]                  o_counter_value,
  output logic [15:0]                  o_capture_register,
  output logic [15:0]                  o_compare_register_a,
  output logic                         o_capture_flag,
  output logic                         o_capture_irq,
  output logic                         o_overflow_flag,
  output logic                         o_overflow_irq,
  output logic                         o_at_top,
  output logic                         o_at_bottom,
  output logic                         o_count_down
);
  import timer16_pkg::*;

  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] a,
                                         input logic [15:0] c);
    logic [15:0] t;
    t = TOP_MAX;
    case (m)
      WM_PC8, WM_FAST8:                             t = TOP_8BIT;
      WM_PC9, WM_FAST9:                             t = TOP_9BIT;
      WM_PC10, WM_FAST10:                           t = TOP_10BIT;
      WM_CTC_A, WM_PFC_A, WM_PC_A, WM_FAST_A:       t = a;
      WM_PFC_CAP, WM_PC_CAP, WM_CTC_CAP, WM_FAST_CAP: t = c;
      default:                                      t = TOP_MAX;
    endcase
    return t;
  endfunction

  function automatic logic dual_slope(input logic [3:0] m);
    return (m inside {WM_PC8, WM_PC9, WM_PC10, WM_PFC_CAP, WM_PFC_A, WM_PC_CAP, WM_PC_A});
  endfunction

  function automatic logic cap_is_top(input logic [3:0] m);
    return (m inside {WM_PFC_CAP, WM_PC_CAP, WM_CTC_CAP, WM_FAST_CAP});
  endfunction

  // registered state
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] cap_r, cap_nxt;
  logic [15:0] cmpa_r, cmpa_nxt;
  logic [7:0]  temp_r, temp_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        down_r, down_nxt;
  logic        cap_flag_r, cap_flag_nxt;
  logic        ovf_flag_r, ovf_flag_nxt;
  logic        ext_prev_r, ext_prev_nxt;
  logic        samp_r, samp_nxt;
  logic [2:0]  hist_r, hist_nxt;
  logic        filt_r, filt_nxt;
  logic        lvl_prev_r, lvl_prev_nxt;

  // combinational helpers
  logic [15:0] top;
  logic        tick;
  logic        trig_src;
  logic        level;
  logic        edge_ok;
  logic        cap_event;
  logic        ovf_event;
  logic        wr_lo;
  logic [15:0] wr_word;

  always_comb begin
    top = top_of(i_ctrl.waveform_mode_field, cmpa_r, cap_r);
    // pin reflects port output too, so a software pin write triggers
    trig_src = i_ctrl.comparator_capture_select ? i_comparator_output
                                                : i_capture_pin;
    // filtered level is the unfiltered one plus four clocks
    level = i_ctrl.capture_noise_filter_enable ? filt_r : samp_r;
    edge_ok = i_ctrl.capture_edge_rising ? (level & ~lvl_prev_r)
                                         : (~level & lvl_prev_r);
    // capture inputs gated off when capture defines top
    cap_event = edge_ok & ~cap_is_top(i_ctrl.waveform_mode_field);
    // tick selection
    case (i_ctrl.tick_source_select)
      TICK_NONE:   tick = 1'b0;
      TICK_SYS:    tick = 1'b1;
      // prescaled strobes listed one by one, so no index can leave the vector
      3'h2:        tick = i_prescale_tick[0];
      3'h3:        tick = i_prescale_tick[1];
      3'h4:        tick = i_prescale_tick[2];
      3'h5:        tick = i_prescale_tick[3];
      TICK_EXT_FE: tick = ext_prev_r & ~i_ext_tick_pin;
      TICK_EXT_RE: tick = ~ext_prev_r & i_ext_tick_pin;
      default:     tick = 1'b0;
    endcase
    wr_lo = i_cpu_req.wr & (i_cpu_req.sel == SEL_CNT_LOW);
    wr_word = {temp_r, i_cpu_req.wdata};
  end

  // filter and edge detector run every system clock, not on tick
  always_comb begin
    samp_nxt = trig_src;
    hist_nxt = {hist_r[1:0], samp_r};
    filt_nxt = filt_r;
    if ((hist_r == {(FILT_LEN - 1){samp_r}}) && (samp_r != filt_r)) begin
      filt_nxt = samp_r;
    end
    lvl_prev_nxt = level;
    ext_prev_nxt = i_ext_tick_pin;
  end

  // counter sequence and overflow
  always_comb begin
    cnt_nxt = cnt_r;
    down_nxt = down_r;
    ovf_event = 1'b0;
    if (tick) begin
      if (dual_slope(i_ctrl.waveform_mode_field)) begin
        if (down_r && cnt_r == CNT_BOTTOM) begin
          down_nxt = 1'b0;
          cnt_nxt = cnt_r + 16'h0001;
          ovf_event = 1'b1;  // dual slope flags at bottom
        end else if (!down_r && cnt_r >= top) begin
          down_nxt = 1'b1;
          cnt_nxt = cnt_r - 16'h0001;
        end else begin
          cnt_nxt = down_r ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
        end
      end else begin
        down_nxt = 1'b0;
        if (cnt_r == top) begin
          cnt_nxt = CNT_BOTTOM;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
        // normal and ctc flag at max, fast pwm at top
        case (i_ctrl.waveform_mode_field)
          WM_CTC_A, WM_CTC_CAP: ovf_event = (cnt_r == TOP_MAX);
          default:              ovf_event = (cnt_r == top);
        endcase
      end
    end
    // cpu write wins, and works with no tick running
    if (wr_lo) begin
      cnt_nxt = wr_word;
    end
  end

  // cpu access, latch, capture register and flags
  always_comb begin
    temp_nxt = temp_r;
    rdata_nxt = rdata_r;
    cap_nxt = cap_r;
    cmpa_nxt = cmpa_r;
    if (i_cpu_req.rd) begin
      if (i_cpu_req.sel == SEL_CNT_LOW) begin
        rdata_nxt = cnt_r[7:0];
        temp_nxt = cnt_r[15:8];
      end else if (i_cpu_req.sel == SEL_CAP_LOW) begin
        rdata_nxt = cap_r[7:0];
        temp_nxt = cap_r[15:8];
      end else if (i_cpu_req.sel == SEL_CMPA_LOW) begin
        rdata_nxt = cmpa_r[7:0];
      end else if (i_cpu_req.sel == SEL_CMPA_HIGH) begin
        rdata_nxt = cmpa_r[15:8];  // compare a bypasses the latch
      end else begin
        rdata_nxt = temp_r;
      end
    end
    if (i_cpu_req.wr) begin
      if (i_cpu_req.sel == SEL_CNT_HIGH || i_cpu_req.sel == SEL_CAP_HIGH
          || i_cpu_req.sel == SEL_CMPA_HIGH) begin
        temp_nxt = i_cpu_req.wdata;  // latch kept for reuse
      end else if (i_cpu_req.sel == SEL_CAP_LOW) begin
        if (cap_is_top(i_ctrl.waveform_mode_field)) begin
          cap_nxt = wr_word;
        end
      end else if (i_cpu_req.sel == SEL_CMPA_LOW) begin
        cmpa_nxt = wr_word;
      end
    end
    // unread values are simply lost on a new capture
    if (cap_event) begin
      cap_nxt = cnt_r;
    end
    // set wins over either kind of clear
    cap_flag_nxt = cap_flag_r;
    if (i_capture_flag_clear || i_capture_irq_ack) begin
      cap_flag_nxt = 1'b0;
    end
    if (cap_event) begin
      cap_flag_nxt = 1'b1;  // same clock as the copy
    end
    ovf_flag_nxt = ovf_flag_r;
    if (i_overflow_flag_clear || i_overflow_irq_ack) begin
      ovf_flag_nxt = 1'b0;
    end
    if (ovf_event) begin
      ovf_flag_nxt = 1'b1;
    end
  end

  // filter and edge history
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ext_prev_r <= 1'b0;
      samp_r     <= 1'b0;
      hist_r     <= 3'h0;
      filt_r     <= 1'b0;
      lvl_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_prev_nxt;
      samp_r     <= samp_nxt;
      hist_r     <= hist_nxt;
      filt_r     <= filt_nxt;
      lvl_prev_r <= lvl_prev_nxt;
    end
  end

  // counter and direction
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_r  <= CNT_RST;
      down_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      down_r <= down_nxt;
    end
  end

  // cpu side, capture register and flags
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      cap_r      <= CAP_RST;
      cmpa_r     <= CMPA_RST;
      temp_r     <= TEMP_RST;
      rdata_r    <= 8'h00;
      cap_flag_r <= 1'b0;
      ovf_flag_r <= 1'b0;
    end else begin
      cap_r      <= cap_nxt;
      cmpa_r     <= cmpa_nxt;
      temp_r     <= temp_nxt;
      rdata_r    <= rdata_nxt;
      cap_flag_r <= cap_flag_nxt;
      ovf_flag_r <= ovf_flag_nxt;
    end
  end

  assign o_cpu_rdata          = rdata_r;
  assign o_counter_value      = cnt_r;
  assign o_capture_register   = cap_r;
  assign o_compare_register_a = cmpa_r;
  assign o_capture_flag       = cap_flag_r;
  assign o_capture_irq        = cap_flag_r & i_ctrl.capture_interrupt_enable;
  assign o_overflow_flag      = ovf_flag_r;
  assign o_overflow_irq       = ovf_flag_r & i_ctrl.overflow_interrupt_enable;
  assign o_at_top             = (cnt_r == top);
  assign o_at_bottom          = (cnt_r == CNT_BOTTOM);
  assign o_count_down         = down_r;
endmodule
`default_nettype wire

/* File: shared/timer16_pkg.sv */
/*
  constants and carrier types for the 16-bit counter and capture block.
  assumes one clock domain and a cpu side that issues byte accesses.
*/
`default_nettype none
package timer16_pkg;
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [15:0] CAP_RST    = 16'h0000;
  localparam logic [15:0] CMPA_RST   = 16'h0000;
  localparam logic [7:0]  TEMP_RST   = 8'h00;
  localparam logic [15:0] TOP_8BIT   = 16'h00FF;
  localparam logic [15:0] TOP_9BIT   = 16'h01FF;
  localparam logic [15:0] TOP_10BIT  = 16'h03FF;
  localparam logic [15:0] TOP_MAX    = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam int          FILT_LEN   = 4;
  // tick source codes
  localparam logic [2:0] TICK_NONE   = 3'h0;
  localparam logic [2:0] TICK_SYS    = 3'h1;
  localparam logic [2:0] TICK_EXT_FE = 3'h6;
  localparam logic [2:0] TICK_EXT_RE = 3'h7;
  // waveform modes
  localparam logic [3:0] WM_NORMAL   = 4'h0;
  localparam logic [3:0] WM_PC8      = 4'h1;
  localparam logic [3:0] WM_PC9      = 4'h2;
  localparam logic [3:0] WM_PC10     = 4'h3;
  localparam logic [3:0] WM_CTC_A    = 4'h4;
  localparam logic [3:0] WM_FAST8    = 4'h5;
  localparam logic [3:0] WM_FAST9    = 4'h6;
  localparam logic [3:0] WM_FAST10   = 4'h7;
  localparam logic [3:0] WM_PFC_CAP  = 4'h8;
  localparam logic [3:0] WM_PFC_A    = 4'h9;
  localparam logic [3:0] WM_PC_CAP   = 4'hA;
  localparam logic [3:0] WM_PC_A     = 4'hB;
  localparam logic [3:0] WM_CTC_CAP  = 4'hC;
  localparam logic [3:0] WM_FAST_CAP = 4'hE;
  localparam logic [3:0] WM_FAST_A   = 4'hF;

  typedef enum logic [2:0] {
    SEL_CNT_LOW, SEL_CNT_HIGH, SEL_CAP_LOW, SEL_CAP_HIGH, SEL_CMPA_LOW, SEL_CMPA_HIGH
  } reg_sel_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    reg_sel_t   sel;
    logic [7:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic [2:0] tick_source_select;
    logic [3:0] waveform_mode_field;
    logic       capture_noise_filter_enable;
    logic       capture_edge_rising;
    logic       comparator_capture_select;
    logic       capture_interrupt_enable;
    logic       overflow_interrupt_enable;
  } timer_ctrl_t;
endpackage
`default_nettype wire

/* File: tb/cic_props.sv */
/*
  port assertions for the counter and capture block.
  assumes it is bound to the top module with one clock.
*/
`default_nettype none
module cic_props (
  // clock and reset
  input wire logic                     i_ref_clk,
  input wire logic                     i_reset,
  // watched ports
  input wire timer16_pkg::cpu_req_t    i_cpu_req,
  input wire logic [7:0]               o_cpu_rdata,
  input wire timer16_pkg::timer_ctrl_t i_ctrl,
  input wire logic                     i_capture_flag_clear,
  input wire logic                     i_capture_irq_ack,
  input wire logic [15:0]              o_counter_value,
  input wire logic [15:0]              o_capture_register,
  input wire logic                     o_capture_flag,
  input wire logic                     o_capture_irq,
  input wire logic                     o_at_bottom
);
  timeunit 1ns;
  timeprecision 1ns;
  import timer16_pkg::*;
  logic [3:0] wm;
  logic       cap_top;
  assign wm = i_ctrl.waveform_mode_field;
  // modes 8, 10, 12 and 14
  assign cap_top = wm[3] && !wm[0];
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  bottom_flag_a: assert property (o_at_bottom == (o_counter_value == CNT_BOTTOM))
    else $error("bottom flag wrong");
  stop_hold_a: assert property (i_ctrl.tick_source_select == TICK_NONE && !i_cpu_req.wr
    |=> $stable(o_counter_value)) else $error("stopped counter moved");
  count_up_a: assert property (wm == WM_NORMAL && i_ctrl.tick_source_select == TICK_SYS
    && !i_cpu_req.wr |=> o_counter_value == $past(o_counter_value) + 16'h0001)
    else $error("counter did not step");
  write_commit_a: assert property (i_cpu_req.wr && i_cpu_req.sel == SEL_CNT_HIGH
    ##1 i_cpu_req.wr && i_cpu_req.sel == SEL_CNT_LOW
    |=> o_counter_value == {$past(i_cpu_req.wdata, 2), $past(i_cpu_req.wdata)})
    else $error("counter write lost");
  latch_read_a: assert property (i_cpu_req.rd && i_cpu_req.sel == SEL_CNT_LOW
    ##1 i_cpu_req.rd && i_cpu_req.sel == SEL_CNT_HIGH
    |=> o_cpu_rdata == $past(o_counter_value[15:8], 2)) else $error("latch read wrong");
  cap_copy_a: assert property ($rose(o_capture_flag)
    |-> o_capture_register == $past(o_counter_value)) else $error("capture value wrong");
  flag_clear_a: assert property (i_capture_flag_clear || i_capture_irq_ack
    |=> !o_capture_flag || $changed(o_capture_register)) else $error("flag not cleared");
  cap_irq_a: assert property (o_capture_irq ==
    (o_capture_flag && i_ctrl.capture_interrupt_enable)) else $error("capture irq wrong");
  cap_block_a: assert property (cap_top [*8] |=> !$rose(o_capture_flag))
    else $error("capture in top mode");
  cover property ($rose(o_capture_flag));
  cover property (i_cpu_req.wr && i_cpu_req.sel == SEL_CAP_LOW && cap_top);
  cover property (i_cpu_req.rd && i_cpu_req.sel == SEL_CAP_LOW);
endmodule
bind timer16_counter_input_capture cic_props i_cic_props (.i_ref_clk, .i_reset,
  .i_cpu_req, .o_cpu_rdata, .i_ctrl, .i_capture_flag_clear, .i_capture_irq_ack,
  .o_counter_value, .o_capture_register, .o_capture_flag, .o_capture_irq, .o_at_bottom);
`default_nettype wire

/* File: tb/cpu_model.sv */
/*
  cpu side model: 16-bit accesses as byte strobes on the timer bus.
  assumes requests change at the falling edge of i_ref_clk.
*/
`default_nettype none
module cpu_model (
  // clock
  input  wire logic                 i_ref_clk,
  // byte bus
  output var timer16_pkg::cpu_req_t o_cpu_req,
  input  wire logic [7:0]           i_cpu_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import timer16_pkg::*;
  initial o_cpu_req = '0;
  task automatic put(input logic r, w, input reg_sel_t s, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_cpu_req = '{r, w, s, d};
  endtask
  // high byte first, low byte commits; no latch reuse here
  task automatic write16(input reg_sel_t hi, lo, input logic [15:0] v);
    put(1'b0, 1'b1, hi, v[15:8]);
    put(1'b0, 1'b1, lo, v[7:0]);
    put(1'b0, 1'b0, lo, 8'h00);
  endtask
  // low byte first so the latch holds the matching high byte
  task automatic read16(input reg_sel_t lo, hi, output logic [15:0] v);
    put(1'b1, 1'b0, lo, 8'h00);
    put(1'b1, 1'b0, hi, 8'h00);
    v[7:0] = i_cpu_rdata;
    put(1'b0, 1'b0, hi, 8'h00);
    v[15:8] = i_cpu_rdata;
  endtask
endmodule
`default_nettype wire

/* File: tb/test_timer16_counter_input_capture.sv */
/*
  self-checking bench for the counter and capture block.
  assumes cpu_model and cic_props are compiled before it.
*/
`default_nettype none
module test_timer16_counter_input_capture;
  timeunit 1ns;
  timeprecision 1ns;
  import timer16_pkg::*;
  logic        i_ref_clk = 1'b0, i_reset = 1'b1;
  cpu_req_t    i_cpu_req;
  timer_ctrl_t i_ctrl = '0;
  logic        i_capture_flag_clear = 1'b0, i_capture_irq_ack = 1'b0;
  logic        i_overflow_flag_clear = 1'b0, i_overflow_irq_ack = 1'b0;
  logic [3:0]  i_prescale_tick = 4'h0;
  logic        i_ext_tick_pin = 1'b0, i_capture_pin = 1'b0, i_comparator_output = 1'b0;
  logic [7:0]  o_cpu_rdata;
  logic [15:0] o_counter_value, o_capture_register, o_compare_register_a;
  logic        o_capture_flag, o_capture_irq, o_overflow_flag, o_overflow_irq;
  logic        o_at_top, o_at_bottom, o_count_down;
  int          fail_count = 0, checks = 0, seed = 32'hb429;
  // own stream, so the order of processes at one edge cannot shift the draws
  int          tick_seed = 32'hb429;
  logic        ext_q = 1'b0;
  always #50 i_ref_clk = ~i_ref_clk;
  // tick sources toggle all run so every strobe and pin select code sees traffic
  always @(negedge i_ref_clk) {i_ext_tick_pin, i_prescale_tick} <= 5'($random(tick_seed));
  always @(posedge i_ref_clk) ext_q <= i_ext_tick_pin;
  timer16_counter_input_capture i_timer16_counter_input_capture (.i_ref_clk, .i_reset,
    .i_cpu_req, .o_cpu_rdata, .i_ctrl, .i_capture_flag_clear, .i_capture_irq_ack,
    .i_overflow_flag_clear, .i_overflow_irq_ack, .i_prescale_tick, .i_ext_tick_pin,
    .i_capture_pin, .i_comparator_output, .o_counter_value, .o_capture_register,
    .o_compare_register_a, .o_capture_flag, .o_capture_irq, .o_overflow_flag,
    .o_overflow_irq, .o_at_top, .o_at_bottom, .o_count_down);
  cpu_model i_cpu_model (.i_ref_clk, .o_cpu_req(i_cpu_req), .i_cpu_rdata(o_cpu_rdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic clr_flag(input logic use_ack);
    i_capture_irq_ack = use_ack;
    i_capture_flag_clear = !use_ack;
    wait_n(1);
    {i_capture_irq_ack, i_capture_flag_clear} = 2'b00;
  endtask
  // edges from input change to flag: two, plus four through the filter
  function automatic int cap_lat(input logic flt);
    return flt ? 6 : 2;
  endfunction
  // tick the select code should pass on: strobe bit, or pin edge vs last sample
  function automatic logic tick_of(input logic [2:0] s, input logic [3:0] p,
                                   input logic e, input logic q);
    if (s == TICK_EXT_FE) return q & ~e;
    if (s == TICK_EXT_RE) return e & ~q;
    return p[s - 3'h2];
  endfunction
  initial begin
    logic [15:0] v, r, e_cnt;
    logic        pol, src, flt;
    wait_n(16);
    i_reset = 1'b0;
    chk(o_counter_value, CNT_RST);
    chk(o_capture_register, CAP_RST);
    chk({15'h0, o_capture_flag}, 16'h0000);
    v = 16'($random(seed));
    i_cpu_model.write16(SEL_CNT_HIGH, SEL_CNT_LOW, v);
    i_cpu_model.read16(SEL_CNT_LOW, SEL_CNT_HIGH, r);
    chk(r, v);
    // latch still holds the counter's high byte, so a low write reuses it
    i_cpu_model.put(1'b0, 1'b1, SEL_CMPA_LOW, ~v[7:0]);
    i_cpu_model.put(1'b0, 1'b0, SEL_CMPA_LOW, 8'h00);
    chk(o_compare_register_a, {v[15:8], ~v[7:0]});
    i_ctrl.tick_source_select = TICK_SYS;
    i_ctrl.overflow_interrupt_enable = 1'b1;
    i_cpu_model.write16(SEL_CNT_HIGH, SEL_CNT_LOW, 16'hFFFD);
    chk(o_counter_value, 16'hFFFD);
    wait_n(3);
    chk(o_counter_value, 16'h0000);
    chk({15'h0, o_overflow_flag}, 16'h0001);
    chk({15'h0, o_overflow_irq}, 16'h0001);
    chk({15'h0, o_at_bottom}, 16'h0001);
    {i_overflow_irq_ack, i_overflow_flag_clear} = 2'b11;
    wait_n(1);
    {i_overflow_irq_ack, i_overflow_flag_clear} = 2'b00;
    chk({15'h0, o_overflow_flag}, 16'h0000);
    i_ctrl.waveform_mode_field = WM_PC8;
    i_cpu_model.write16(SEL_CNT_HIGH, SEL_CNT_LOW, 16'h00FE);
    wait_n(1);
    chk({15'h0, o_at_top}, 16'h0001);
    wait_n(2);
    chk(o_counter_value, 16'h00FD);
    chk({15'h0, o_count_down}, 16'h0001);
    // prescaled strobes and both pin edges, counted against the pins seen
    i_ctrl.waveform_mode_field = WM_NORMAL;
    for (int s = 2; s < 8; s++) begin
      i_ctrl.tick_source_select = 3'(s);
      e_cnt = o_counter_value;
      repeat (12) begin
        @(posedge i_ref_clk);
        e_cnt = e_cnt + 16'(tick_of(3'(s), i_prescale_tick, i_ext_tick_pin, ext_q));
      end
      @(negedge i_ref_clk);
      chk(o_counter_value, e_cnt);
    end
    i_ctrl.tick_source_select = TICK_NONE;
    i_ctrl.waveform_mode_field = WM_NORMAL;
    // counter held still while capturing
    for (int k = 0; k < 8; k++) begin
      v = 16'($random(seed));
      {pol, src, flt} = 3'($random(seed));
      i_ctrl.capture_edge_rising = pol;
      i_ctrl.comparator_capture_select = src;
      i_ctrl.capture_noise_filter_enable = flt;
      i_ctrl.capture_interrupt_enable = k[0];
      {i_capture_pin, i_comparator_output} = {2{!pol}};
      i_cpu_model.write16(SEL_CNT_HIGH, SEL_CNT_LOW, v);
      wait_n(8);
      clr_flag(k[1]);
      if (src) i_comparator_output = pol;
      else i_capture_pin = pol;
      wait_n(cap_lat(flt) - 1);
      chk({15'h0, o_capture_flag}, 16'h0000);
      wait_n(1);
      chk({15'h0, o_capture_flag}, 16'h0001);
      chk({15'h0, o_capture_irq}, {15'h0, k[0]});
      i_cpu_model.read16(SEL_CAP_LOW, SEL_CAP_HIGH, r);
      chk(r, v);
      clr_flag(k[1]);
      chk({15'h0, o_capture_flag}, 16'h0000);
      {i_capture_pin, i_comparator_output} = {2{!pol}};
      wait_n(8);
      chk({15'h0, o_capture_flag}, 16'h0000);
    end
    i_ctrl = '{default: 1'b0, capture_noise_filter_enable: 1'b1, capture_edge_rising: 1'b1};
    i_capture_pin = 1'b0;
    wait_n(8);
    clr_flag(1'b0);
    i_capture_pin = 1'b1;
    wait_n(3);
    i_capture_pin = 1'b0;
    wait_n(10);
    chk({15'h0, o_capture_flag}, 16'h0000);
    i_cpu_model.write16(SEL_CAP_HIGH, SEL_CAP_LOW, ~v);
    i_cpu_model.read16(SEL_CAP_LOW, SEL_CAP_HIGH, r);
    chk(r, v);
    i_ctrl.waveform_mode_field = WM_CTC_CAP;
    v = 16'($random(seed));
    i_cpu_model.write16(SEL_CAP_HIGH, SEL_CAP_LOW, v);
    i_capture_pin = 1'b1;
    i_cpu_model.read16(SEL_CAP_LOW, SEL_CAP_HIGH, r);
    chk(r, v);
    wait_n(10);
    chk({15'h0, o_capture_flag}, 16'h0000);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    fail_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
